// file: gpio_out_pkg.sv
// Constants shared by the pin output and pull control block
package gpio_out_pkg;

	// ==========================================================
	// Register offsets (byte addresses as seen on the register port)
	localparam logic [31:0] OFFSET_LEVEL_LOW   = 32'h0B00011C;
	localparam logic [31:0] OFFSET_LEVEL_HIGH  = 32'h0B00011E;
	localparam logic [31:0] OFFSET_PULL_USAGE  = 32'h0B0002E0;

	// ==========================================================
	// Field positions
	localparam int          LEVEL_HIGH_LSB     = 0;
	localparam int          ENABLE_HIGH_LSB    = 8;
	localparam int          HIGH_PIN_COUNT     = 2;
	localparam int          PULL_PIN_COUNT     = 15;
	localparam int          LOW_PIN_COUNT      = 16;
	localparam int          DIR_SELECT_WIDTH   = 16;

	// ==========================================================
	// Reset values taken on the real-time-clock reset
	localparam logic [15:0] RESET_LEVEL_LOW    = 16'h0FFF;
	localparam logic [1:0]  RESET_LEVEL_HIGH   = 2'h0;
	localparam logic [1:0]  RESET_ENABLE_HIGH  = 2'h0;
	localparam logic [14:0] RESET_PULL_USAGE   = 15'h0000;

	// ==========================================================
	// Register selection
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_LEVEL_LOW,
		SEL_LEVEL_HIGH,
		SEL_PULL_USAGE
	} reg_select_e;

	function automatic reg_select_e decodeAddress(input logic [31:0] addr);
		reg_select_e sel;
		sel = SEL_NONE;
		if (addr == OFFSET_LEVEL_LOW)
			sel = SEL_LEVEL_LOW;
		else if (addr == OFFSET_LEVEL_HIGH)
			sel = SEL_LEVEL_HIGH;
		else if (addr == OFFSET_PULL_USAGE)
			sel = SEL_PULL_USAGE;
		return sel;
	endfunction : decodeAddress

endpackage : gpio_out_pkg

// file: pull_if.sv
// Interface carrying pull settings to the pull resolver and its results back
`timescale 1ns/100ps
`default_nettype none
interface pull_if;
	import gpio_out_pkg::*;

	logic [PULL_PIN_COUNT-1:0]   pullUsage;
	logic [PULL_PIN_COUNT-1:0]   pullPolarity;
	logic [DIR_SELECT_WIDTH-1:0] dirSelectLow;
	logic [PULL_PIN_COUNT-1:0]   pullUpOn;
	logic [PULL_PIN_COUNT-1:0]   pullDownOn;

	modport source (
		output pullUsage,
		output pullPolarity,
		output dirSelectLow,
		input  pullUpOn,
		input  pullDownOn
	);

	modport resolver (
		input  pullUsage,
		input  pullPolarity,
		input  dirSelectLow,
		output pullUpOn,
		output pullDownOn
	);
endinterface : pull_if
`default_nettype wire

// file: pull_resolver.sv
// Turns pull usage, polarity and direction select into registered pull controls
`timescale 1ns/100ps
`default_nettype none
module pull_resolver
	import gpio_out_pkg::*;
(
	// Clock and reset
	input  wire logic   core_clk,
	input  wire logic   reset,
	// Pull settings and results
	pull_if.resolver    pull
);

	typedef struct packed {
		logic [PULL_PIN_COUNT-1:0] up;
		logic [PULL_PIN_COUNT-1:0] down;
	} pull_state_s;

	pull_state_s st;
	pull_state_s next_st;
	logic        allInputs;

	// ==========================================================
	// Pull resolution
	always_comb
	begin
		next_st   = st;
		// Pulls act only while every low-bank pin is an input
		allInputs = (pull.dirSelectLow == '0);
		if (allInputs)
		begin
			next_st.up   = pull.pullUsage & pull.pullPolarity;
			next_st.down = pull.pullUsage & ~pull.pullPolarity;
		end
		else
		begin
			next_st.up   = '0;
			next_st.down = '0;
		end
	end

	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			st <= '0;
		else
			st <= next_st;
	end

	assign pull.pullUpOn   = st.up;
	assign pull.pullDownOn = st.down;

	// ==========================================================
	// Checks
	a_pull_gated_off : assert property (@(posedge core_clk) disable iff (reset)
		(pull.dirSelectLow != '0) |=> (pull.pullUpOn == '0) && (pull.pullDownOn == '0))
		else $error("pull active while a low-bank pin is an output");

	a_pull_polarity_up : assert property (@(posedge core_clk) disable iff (reset)
		(pull.dirSelectLow == '0) |=>
			(pull.pullUpOn == ($past(pull.pullUsage) & $past(pull.pullPolarity)))
			&& ((pull.pullUpOn & pull.pullDownOn) == '0))
		else $error("pull direction does not follow usage and polarity");

endmodule : pull_resolver
`default_nettype wire

// file: gpio_output_data_and_pull_control.sv
// Pin output data, output enables and pull usage control with register port
//
// Contract
// - Each written output data bit drives its pin: 1 high, 0 low.
// - Reading an output data bit returns the written value, not the pin.
// - Low data register: bits 0..15 drive pins 32..47 in order.
// - Resets other than the clock-domain reset keep every field unchanged.
// - Pins 47..44 share serial lines; pins 43..32 share keyboard scan lines.
// - High register bit 9 enables pin 49 driver, bit 8 pin 48.
// - High register bits 1 and 0 give levels of pins 49 and 48.
// - Pin 48 shares the wide bus indicator; output use excludes it.
// - Reserved bits read zero; software writes zero to them.
// - Pin 49 is input during clock-domain reset, output otherwise; here it stays undriven after reset until bit 9 is written 1.
// - Pull usage register: one bit per pin 0..14, 1 activates pull.
// - With pull active, the polarity bit chooses pull up or down.
// - Pulls act only while all low direction select bits are zero.
// - Pin 15 has no pull control; usage bit 15 is reserved.
// - Polarity 1 selects pull-up, 0 selects pull-down.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module gpio_output_data_and_pull_control
	import gpio_out_pkg::*;
#(
	parameter int ADDR_WIDTH = 32
)
(
	// Clock and resets
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	input  wire logic                        sysReset,
	// Register port
	input  wire logic [ADDR_WIDTH-1:0]       regAddr,
	input  wire logic [15:0]                 regWrData,
	input  wire logic                        regWrite,
	input  wire logic                        regRead,
	output logic      [15:0]                 regRdData,
	// Output-only pins 32 to 47
	output logic      [LOW_PIN_COUNT-1:0]    pinOutLevel,
	// Pins 48 and 49
	output logic                             pin48Level,
	output logic                             pin48OutEnableN,
	output logic                             pin49Level,
	output logic                             pin49OutEnableN,
	// Pull controls for pins 0 to 14
	input  wire logic [PULL_PIN_COUNT-1:0]   pullPolarity,
	input  wire logic [DIR_SELECT_WIDTH-1:0] dirSelectLow,
	output logic      [PULL_PIN_COUNT-1:0]   pullUpOn,
	output logic      [PULL_PIN_COUNT-1:0]   pullDownOn
);

	typedef struct packed {
		logic [LOW_PIN_COUNT-1:0]  levelLow;
		logic [HIGH_PIN_COUNT-1:0] levelHigh;
		logic [HIGH_PIN_COUNT-1:0] outEnableN;
		logic [PULL_PIN_COUNT-1:0] pullUsage;
		logic [15:0]               rdData;
	} state_s;

	state_s      st;
	state_s      next_st;
	reg_select_e wrSel;
	reg_select_e rdSel;
	logic        busOpen;
	logic [31:0] fullAddr;

	pull_if pull ();

	// ==========================================================
	// Address decode
	always_comb
	begin
		fullAddr = 32'(regAddr);
		wrSel    = decodeAddress(fullAddr);
		rdSel    = decodeAddress(fullAddr);
		// Register port is ignored while another reset holds the system
		busOpen  = !sysReset;
	end

	// ==========================================================
	// Register writes and read data
	always_comb
	begin
		next_st        = st;
		next_st.rdData = 16'h0000;

		if (busOpen && regWrite)
		begin
			if (wrSel == SEL_LEVEL_LOW)
			begin
				// Bit n drives pin 32+n; pins 44..47 and 32..43 are shared outputs
				next_st.levelLow = regWrData;
			end
			else if (wrSel == SEL_LEVEL_HIGH)
			begin
				next_st.levelHigh  = regWrData[LEVEL_HIGH_LSB +: HIGH_PIN_COUNT];
				// Enable stored inverted so the pin enable is a flop output
				next_st.outEnableN = ~regWrData[ENABLE_HIGH_LSB +: HIGH_PIN_COUNT];
			end
			else if (wrSel == SEL_PULL_USAGE)
			begin
				// Bit 15 has no storage: pin 15 is the carrier detect input
				next_st.pullUsage = regWrData[PULL_PIN_COUNT-1:0];
			end
		end

		if (busOpen && regRead)
		begin
			if (rdSel == SEL_LEVEL_LOW)
			begin
				next_st.rdData = st.levelLow;
			end
			else if (rdSel == SEL_LEVEL_HIGH)
			begin
				next_st.rdData[LEVEL_HIGH_LSB +: HIGH_PIN_COUNT]  = st.levelHigh;
				next_st.rdData[ENABLE_HIGH_LSB +: HIGH_PIN_COUNT] = ~st.outEnableN;
			end
			else if (rdSel == SEL_PULL_USAGE)
			begin
				next_st.rdData[PULL_PIN_COUNT-1:0] = st.pullUsage;
			end
		end
	end

	// Only the clock-domain reset loads defaults; pins 48/49 come up undriven
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			st.levelLow   <= RESET_LEVEL_LOW;
			st.levelHigh  <= RESET_LEVEL_HIGH;
			st.outEnableN <= ~RESET_ENABLE_HIGH;
			st.pullUsage  <= RESET_PULL_USAGE;
			st.rdData     <= 16'h0000;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Pull resolution
	assign pull.pullUsage    = st.pullUsage;
	assign pull.pullPolarity = pullPolarity;
	assign pull.dirSelectLow = dirSelectLow;

	pull_resolver u_pull_resolver (
		.core_clk (core_clk),
		.reset    (reset),
		.pull     (pull.resolver)
	);

	// ==========================================================
	// Outputs
	assign regRdData       = st.rdData;
	assign pinOutLevel     = st.levelLow;
	assign pin48Level      = st.levelHigh[0];
	assign pin49Level      = st.levelHigh[1];
	// Pin not driven while its enable bit is zero
	assign pin48OutEnableN = st.outEnableN[0];
	assign pin49OutEnableN = st.outEnableN[1];
	assign pullUpOn        = pull.pullUpOn;
	assign pullDownOn      = pull.pullDownOn;

	// ==========================================================
	// Checks
	default clocking cb @(posedge core_clk);
	endclocking

	default disable iff (reset);

	sequence s_write_low;
		regWrite && !sysReset && (fullAddr == OFFSET_LEVEL_LOW);
	endsequence

	sequence s_write_high;
		regWrite && !sysReset && (fullAddr == OFFSET_LEVEL_HIGH);
	endsequence

	sequence s_read_low;
		regRead && !sysReset && (fullAddr == OFFSET_LEVEL_LOW);
	endsequence

	sequence s_read_high;
		regRead && !sysReset && (fullAddr == OFFSET_LEVEL_HIGH);
	endsequence

	sequence s_read_pull;
		regRead && !sysReset && (fullAddr == OFFSET_PULL_USAGE);
	endsequence

	a_low_write_drive : assert property (
		s_write_low |=> (pinOutLevel == $past(regWrData)))
		else $error("low pin levels do not follow the written data");

	a_low_read_back : assert property (
		s_write_low ##1 s_read_low |=> (regRdData == $past(regWrData, 2)))
		else $error("low register read does not return the written value");

	a_high_enable_map : assert property (
		s_write_high |=> (pin49OutEnableN == !$past(regWrData[9]))
			&& (pin48OutEnableN == !$past(regWrData[8])))
		else $error("pin 48/49 drive enables do not follow bits 8 and 9");

	a_high_level_map : assert property (
		s_write_high |=> (pin49Level == $past(regWrData[1]))
			&& (pin48Level == $past(regWrData[0])))
		else $error("pin 48/49 levels do not follow bits 0 and 1");

	a_reserved_reads_zero : assert property (
		s_read_high |=> (regRdData[15:10] == 6'h00) && (regRdData[7:2] == 6'h00))
		else $error("reserved bits of the high register read nonzero");

	a_pull_bit15_zero : assert property (
		s_read_pull |=> (regRdData[15] == 1'b0))
		else $error("pull usage bit 15 reads nonzero");

	a_other_reset_holds : assert property (
		sysReset |=> $stable(pinOutLevel) && $stable(pin48Level) && $stable(pin49Level)
			&& $stable(pin48OutEnableN) && $stable(pin49OutEnableN))
		else $error("pin state changed during another reset");

	a_pin49_input_reset : assert property (@(posedge core_clk) disable iff (1'b0)
		reset |-> pin49OutEnableN && pin48OutEnableN)
		else $error("pin 49 driven during the clock-domain reset");

	a_unmapped_read_zero : assert property (
		(regRead && (decodeAddress(fullAddr) == SEL_NONE)) |=> (regRdData == 16'h0000))
		else $error("unmapped read returned nonzero data");

	a_pull_usage_gate : assert property (
		(dirSelectLow == '0) ##1 (dirSelectLow == '0)
			|=> ((pullUpOn | pullDownOn) == $past(st.pullUsage)))
		else $error("active pulls do not match the usage bits");

	// ==========================================================
	// Register port, hold and reset default checks

	sequence s_write_pull;
		regWrite && !sysReset && (fullAddr == OFFSET_PULL_USAGE);
	endsequence

	sequence s_blocked_access;
		(regWrite || regRead) && sysReset;
	endsequence

	sequence s_no_write;
		!(regWrite && !sysReset);
	endsequence

	a_serial_pins_map : assert property (
		s_write_low |=> (pinOutLevel[15:12] == $past(regWrData[15:12]))
			&& (pinOutLevel[11:0] == $past(regWrData[11:0])))
		else $error("shared serial or scan pins do not follow their data bits");

	a_low_bit_order : assert property (
		s_write_low |=> (pinOutLevel[0] == $past(regWrData[0]))
			&& (pinOutLevel[LOW_PIN_COUNT-1] == $past(regWrData[15])))
		else $error("low register bit order does not match pins 32 to 47");

	a_wide_bus_pin : assert property (
		s_write_high |=> (pin48Level == $past(regWrData[LEVEL_HIGH_LSB]))
			&& (pin48OutEnableN == !$past(regWrData[ENABLE_HIGH_LSB])))
		else $error("pin 48 does not follow its data and enable bits");

	a_enable_reads_back : assert property (
		s_read_high |=> (regRdData[9:8] == ~$past({pin49OutEnableN, pin48OutEnableN}))
			&& (regRdData[1:0] == $past({pin49Level, pin48Level})))
		else $error("high register read does not match the pin controls");

	a_pull_write_store : assert property (
		s_write_pull |=> (st.pullUsage == $past(regWrData[PULL_PIN_COUNT-1:0])))
		else $error("pull usage bits not stored from the written data");

	a_pull_read_back : assert property (
		s_read_pull |=> (regRdData[PULL_PIN_COUNT-1:0] == $past(st.pullUsage)))
		else $error("pull usage read does not return the stored bits");

	a_read_data_idle : assert property (
		!(regRead && !sysReset) |=> (regRdData == 16'h0000))
		else $error("read data present without an accepted read strobe");

	a_blocked_read_zero : assert property (
		(regRead && sysReset) |=> (regRdData == 16'h0000))
		else $error("read during another reset returned nonzero data");

	a_blocked_write_ignored : assert property (
		s_blocked_access |=> $stable(pinOutLevel) && $stable(st.pullUsage)
			&& $stable(pin48Level) && $stable(pin49Level))
		else $error("access during another reset changed stored state");

	a_levels_hold_idle : assert property (
		s_no_write |=> $stable(pinOutLevel) && $stable(pin48Level) && $stable(pin49Level)
			&& $stable(pin48OutEnableN) && $stable(pin49OutEnableN))
		else $error("pin outputs changed without a write");

	a_reset_defaults : assert property (
		$fell(reset) |-> (pinOutLevel == RESET_LEVEL_LOW)
			&& ({pin49Level, pin48Level} == RESET_LEVEL_HIGH)
			&& ({pin49OutEnableN, pin48OutEnableN} == ~RESET_ENABLE_HIGH)
			&& (regRdData == 16'h0000))
		else $error("outputs not at their defaults after the clock-domain reset");

	a_pull_reset_clear : assert property (
		$fell(reset) |-> (pullUpOn == '0) && (pullDownOn == '0)
			&& (st.pullUsage == RESET_PULL_USAGE))
		else $error("pull controls not cleared by the clock-domain reset");

endmodule : gpio_output_data_and_pull_control
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the pin output and pull control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("BAD %0t got %h want %h", $time, got, exp); end end
module tb_top
	import gpio_out_pkg::*;
;
	// ==========================================================
	// Stimulus and observed signals
	logic        core_clk     = 1'b0;
	logic        reset        = 1'b0;
	logic        sysReset     = 1'b0;
	logic [31:0] regAddr      = 32'h0;
	logic [15:0] regWrData    = 16'h0;
	logic        regWrite     = 1'b0;
	logic        regRead      = 1'b0;
	logic [15:0] regRdData;
	logic [15:0] pinOutLevel;
	logic        pin48Level;
	logic        pin48OutEnableN;
	logic        pin49Level;
	logic        pin49OutEnableN;
	logic [14:0] pullPolarity = 15'h0;
	logic [15:0] dirSelectLow = 16'h0;
	logic [14:0] pullUpOn;
	logic [14:0] pullDownOn;
	int          n_mismatch   = 0;
	int          num_checks   = 0;

	always #20 core_clk = ~core_clk;

	gpio_output_data_and_pull_control i_dut (
		.core_clk(core_clk), .reset(reset), .sysReset(sysReset),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .pinOutLevel(pinOutLevel),
		.pin48Level(pin48Level), .pin48OutEnableN(pin48OutEnableN),
		.pin49Level(pin49Level), .pin49OutEnableN(pin49OutEnableN),
		.pullPolarity(pullPolarity), .dirSelectLow(dirSelectLow),
		.pullUpOn(pullUpOn), .pullDownOn(pullDownOn)
	);

	// ==========================================================
	// Register port tasks
	task automatic regWr(input logic [31:0] addr, input logic [15:0] data);
		@(posedge core_clk);
		regAddr   <= addr;
		regWrData <= data;
		regWrite  <= 1'b1;
		@(posedge core_clk);
		regWrite  <= 1'b0;
		#1;
	endtask : regWr

	task automatic regRdChk(input logic [31:0] addr, input logic [15:0] exp);
		@(posedge core_clk);
		regAddr <= addr;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1;
		`CHK(regRdData, exp)
	endtask : regRdChk

	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask : tick

	// ==========================================================
	// Scenarios
	task automatic chkReset();
		`CHK(pinOutLevel, 16'h0FFF)
		`CHK({pin49OutEnableN, pin48OutEnableN}, 2'b11)
		`CHK({pin49Level, pin48Level}, 2'b00)
		`CHK({pullUpOn, pullDownOn}, 30'h0)
		regRdChk(OFFSET_LEVEL_LOW, 16'h0FFF);
		regRdChk(OFFSET_LEVEL_HIGH, 16'h0000);
		regRdChk(OFFSET_PULL_USAGE, 16'h0000);
	endtask : chkReset

	task automatic lowData();
		logic [15:0] pat[4] = '{16'h0001, 16'h8000, 16'hA5C3, 16'h0000};
		foreach (pat[i])
		begin
			regWr(OFFSET_LEVEL_LOW, pat[i]);
			`CHK(pinOutLevel, pat[i])
			regRdChk(OFFSET_LEVEL_LOW, pat[i]);
		end
	endtask : lowData

	task automatic highData();
		logic [15:0] pat[4] = '{16'hFFFF, 16'h0201, 16'h0102, 16'h0000};
		foreach (pat[i])
		begin
			regWr(OFFSET_LEVEL_HIGH, pat[i]);
			`CHK({pin49Level, pin48Level}, pat[i][1:0])
			`CHK({pin49OutEnableN, pin48OutEnableN}, ~pat[i][9:8])
			regRdChk(OFFSET_LEVEL_HIGH, pat[i] & 16'h0303);
		end
	endtask : highData

	task automatic pullPath();
		regWr(OFFSET_PULL_USAGE, 16'hFFFF);
		regRdChk(OFFSET_PULL_USAGE, 16'h7FFF);
		@(posedge core_clk);
		pullPolarity <= 15'h5A3C;
		tick();
		`CHK(pullUpOn, 15'h5A3C)
		`CHK(pullDownOn, ~15'h5A3C)
		regWr(OFFSET_PULL_USAGE, 16'h00F0);
		tick();
		`CHK(pullUpOn, 15'h5A3C & 15'h00F0)
		`CHK(pullDownOn, ~15'h5A3C & 15'h00F0)
		@(posedge core_clk);
		dirSelectLow <= 16'h8000;
		tick();
		`CHK({pullUpOn, pullDownOn}, 30'h0)
		@(posedge core_clk);
		dirSelectLow <= 16'h0000;
		tick();
		`CHK(pullUpOn, 15'h0030)
	endtask : pullPath

	task automatic otherReset();
		regWr(OFFSET_LEVEL_LOW, 16'h1234);
		@(posedge core_clk);
		sysReset <= 1'b1;
		regWr(OFFSET_LEVEL_LOW, 16'hFFFF);
		regWr(OFFSET_LEVEL_HIGH, 16'h0303);
		regRdChk(OFFSET_LEVEL_LOW, 16'h0000);
		`CHK(pinOutLevel, 16'h1234)
		`CHK({pin49OutEnableN, pin48OutEnableN}, 2'b11)
		@(posedge core_clk);
		sysReset <= 1'b0;
		regRdChk(OFFSET_LEVEL_LOW, 16'h1234);
	endtask : otherReset

	task automatic unmappedAndBackToBack();
		regWr(32'h0B000120, 16'hFFFF);
		`CHK(pinOutLevel, 16'h1234)
		regRdChk(32'h0B000120, 16'h0000);
		@(posedge core_clk);
		regAddr   <= OFFSET_LEVEL_LOW;
		regWrData <= 16'hC0DE;
		regWrite  <= 1'b1;
		@(posedge core_clk);
		regWrite  <= 1'b0;
		regRead   <= 1'b1;
		@(posedge core_clk);
		regRead   <= 1'b0;
		#1;
		`CHK(regRdData, 16'hC0DE)
		tick();
		`CHK(regRdData, 16'h0000)
	endtask : unmappedAndBackToBack

	task automatic rtcReset();
		regWr(OFFSET_LEVEL_HIGH, 16'h0303);
		regWr(OFFSET_PULL_USAGE, 16'h7FFF);
		@(posedge core_clk);
		reset <= 1'b1;
		#1;
		`CHK({pin49OutEnableN, pin48OutEnableN}, 2'b11)
		`CHK(pinOutLevel, 16'h0FFF)
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		chkReset();
	endtask : rtcReset

	// ==========================================================
	// Run control
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	initial
	begin
		// A real rising edge on reset so the asynchronous branch runs at once
		reset <= 1'b1;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		chkReset();
		lowData();
		highData();
		pullPath();
		otherReset();
		unmappedAndBackToBack();
		rtcReset();
		complete_run();
	end

	initial
	begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		$display("BAD %0t run did not finish", $time);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
